// ### rtl/pllc_pkg.sv
// Shared constants, host register map and checks for the loop control shell.
package pllc_pkg;
  localparam int NOUT = 4;
  localparam int PH_W = 3;
  localparam int FRACTIONAL_PART_W = 24;
  localparam int RDIV_W = 6;
  localparam int FDIV_W = 12;
  localparam int LKL_W = 4;
  localparam int CTL_W = 11;
  localparam int BUS_W = 33;
  localparam logic [RDIV_W-1:0] RDIV_MIN = 6'h01;
  localparam logic [RDIV_W-1:0] RDIV_MAX = 6'h3F;
  localparam logic [FDIV_W-1:0] FDIV_LO_MIN = 12'h008;
  localparam logic [FDIV_W-1:0] FDIV_LO_MAX = 12'h00A;
  localparam logic [FDIV_W-1:0] FDIV_HI_MIN = 12'h00C;
  localparam logic [FDIV_W-1:0] FDIV_HI_MAX = 12'hFFF;
  localparam logic [FDIV_W-1:0] FDIV_FR_MIN = 12'h014;
  localparam logic [FDIV_W-1:0] FDIV_FR_MAX = 12'h1F4;
  localparam logic [LKL_W-1:0] LKL_MIN = 4'h1;
  localparam logic [LKL_W-1:0] LKL_MAX = 4'hF;
  localparam logic [LKL_W-1:0] LKL_RST = 4'h8;
  localparam longint PFD_INT_MIN_HZ = 64'd1000000;
  localparam longint PFD_INT_MAX_HZ = 64'd312000000;
  localparam longint PFD_FR_MIN_HZ = 64'd10000000;
  localparam longint PFD_FR_MAX_HZ = 64'd250000000;
  localparam int CLK_NS = 50;
  localparam int REF_LOSS_NS = 4000;
  localparam int REF_LOSS_CYC = (REF_LOSS_NS + CLK_NS - 1) / CLK_NS;
  localparam int ALIGN_OSC_CYC = 16;
  localparam int RC_VALID = 0;
  localparam int RC_WRITE = 1;
  localparam int RC_ADDR = 2;
  localparam int RC_ACK = 3;
  localparam logic [7:0] RA_STATUS = 8'h0F;
  localparam int RMEM_N = 4;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV = 8'h04;
  localparam logic [7:0] A_FRACTIONAL_PART = 8'h08;
  localparam logic [7:0] A_PHCMD = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_RCTL = 8'h14;
  localparam logic [7:0] A_RWD = 8'h18;
  localparam logic [7:0] A_RRD = 8'h1C;
  localparam int C_RUN = 0;
  localparam int C_SEL = 1;
  localparam int C_AUTO = 2;
  localparam int C_OSC = 3;
  localparam int C_EXTFB = 4;
  localparam int C_FRACTIONAL_PART = 5;
  localparam int C_EN = 8;
  localparam int C_PICK = 12;
  localparam int C_DIR = 16;
  localparam int C_LKL = 20;
  localparam int C_RREL = 24;
  localparam int D_FDIV = 16;
  localparam int P_STEP = 0;
  localparam int P_LOAD = 1;
  localparam int W_BIT32 = 16;
  localparam logic [31:0] CTRL_RST = 32'h0080_0000;
  localparam logic [31:0] DIV_RST = 32'h000C_0001;

  function automatic logic pllc_fdiv_ok(input logic [FDIV_W-1:0] d, input logic fr);
    if (fr) begin
      return d >= FDIV_FR_MIN && d <= FDIV_FR_MAX;
    end
    return (d >= FDIV_LO_MIN && d <= FDIV_LO_MAX) || d >= FDIV_HI_MIN;
  endfunction : pllc_fdiv_ok

  function automatic logic pllc_rdiv_ok(input logic [RDIV_W-1:0] d);
    return d >= RDIV_MIN && d <= RDIV_MAX;
  endfunction : pllc_rdiv_ok
endpackage : pllc_pkg

// ### rtl/pllc_if.sv
// Interface joining the loop control shell and the user fabric end.
`timescale 1ns/1ps
interface pllc_if;
  import pllc_pkg::*;
  logic ref_sel;
  logic loop_powerdown_n;
  logic ext_fb;
  logic fractional_part_mode;
  logic [NOUT-1:0] out_en;
  logic [NOUT-1:0] phase_pick;
  logic phase_dir;
  logic phase_step_strobe;
  logic phase_reload_n;
  logic [RDIV_W-1:0] reference_divider;
  logic [FDIV_W-1:0] feedback_divider;
  logic [FRACTIONAL_PART_W-1:0] fractional_part;
  logic [LKL_W-1:0] lock_delay_log2;
  logic feedback_clock_in;
  logic [NOUT-1:0] out_clk;
  logic lock;
  logic reconfig_if_clock;
  logic reconfig_if_reset_n;
  logic [CTL_W-1:0] reconfig_if_ctrl;
  logic [BUS_W-1:0] reconfig_if_wbus;
  logic [BUS_W-1:0] reconfig_if_rbus;
  logic reconfig_if_irq;
  modport dev (
    input ref_sel, loop_powerdown_n, ext_fb, fractional_part_mode, out_en, phase_pick, phase_dir,
    input phase_step_strobe, phase_reload_n, reference_divider, feedback_divider,
    input fractional_part, lock_delay_log2, feedback_clock_in,
    input reconfig_if_clock, reconfig_if_reset_n, reconfig_if_ctrl, reconfig_if_wbus,
    output out_clk, lock, reconfig_if_rbus, reconfig_if_irq
  );
  modport host (
    output ref_sel, loop_powerdown_n, ext_fb, fractional_part_mode, out_en, phase_pick, phase_dir,
    output phase_step_strobe, phase_reload_n, reference_divider, feedback_divider,
    output fractional_part, lock_delay_log2, feedback_clock_in,
    output reconfig_if_clock, reconfig_if_reset_n, reconfig_if_ctrl, reconfig_if_wbus,
    input out_clk, lock, reconfig_if_rbus, reconfig_if_irq
  );
endinterface : pllc_if

// ### rtl/pllc_dev.sv
// Loop control shell: reference select, dividers, lock delay, output gating, phase and reconfiguration.
`timescale 1ns/1ps
module pllc_dev #(
  parameter logic [pllc_pkg::NOUT*8-1:0] OUT_HALF = {8'h08, 8'h04, 8'h02, 8'h02},
  parameter logic [pllc_pkg::NOUT*pllc_pkg::PH_W-1:0] PHASE_INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  pllc_if.dev bus,
  input wire logic ref_clk0,
  input wire logic ref_clk1,
  output logic ref_present,
  output logic fb_tick,
  output logic [pllc_pkg::NOUT*pllc_pkg::PH_W-1:0] phase_state
);
  import pllc_pkg::*;

  logic loop_rst_n;
  logic rc_rst_n;
  logic ref_mux;
  logic ref_q_r;
  logic ref_edge;
  logic [RDIV_W-1:0] rdiv_cnt_r;
  logic ref_tick;
  logic [7:0] loss_cnt_r;
  logic cfg_ok;
  logic acq;
  logic fb_src_q_r;
  logic fb_step;
  logic [FDIV_W:0] fb_cnt_r;
  logic [FDIV_W:0] fb_mod_r;
  logic [FRACTIONAL_PART_W-1:0] acc_r;
  logic [FRACTIONAL_PART_W:0] acc_nxt;
  logic [15:0] lk_cnt_r;
  logic [15:0] lk_tgt;
  logic [LKL_W-1:0] lkl_c;
  logic lock_r;
  logic str_q_r;
  logic rel_q_r;
  logic step;
  logic reload;
  logic [NOUT-1:0] en_s1_r;
  logic [NOUT-1:0] en_s2_r;
  logic [NOUT-1:0] run_r;
  logic [NOUT-1:0] pend;
  logic [NOUT-1:0] start_r;
  logic [NOUT-1:0] out_r;
  logic win_act_r;
  logic [4:0] win_cnt_r;
  logic rck_q_r;
  logic redge;
  logic [7:0] raddr_r;
  logic [BUS_W-1:0] rmem_r [RMEM_N];
  logic [BUS_W-1:0] rbus_r;
  logic irq_r;
  logic lock_seen_r;

  assign loop_rst_n = presetn & bus.loop_powerdown_n;
  assign rc_rst_n = presetn & bus.reconfig_if_reset_n;
  assign ref_mux = bus.ref_sel ? ref_clk1 : ref_clk0;
  assign ref_edge = ref_mux & ~ref_q_r;
  assign ref_tick = ref_edge && rdiv_cnt_r == bus.reference_divider - 6'h01;
  assign cfg_ok = pllc_rdiv_ok(bus.reference_divider) && pllc_fdiv_ok(bus.feedback_divider, bus.fractional_part_mode);
  assign acq = cfg_ok & ref_present;
  assign fb_step = bus.ext_fb ? (bus.feedback_clock_in & ~fb_src_q_r) : 1'b1;
  assign acc_nxt = {1'b0, acc_r} + {1'b0, bus.fractional_part};
  assign lkl_c = bus.lock_delay_log2 < LKL_MIN ? LKL_MIN : bus.lock_delay_log2;
  assign lk_tgt = 16'h0001 << lkl_c;
  assign step = bus.phase_step_strobe & ~str_q_r;
  assign reload = ~bus.phase_reload_n & rel_q_r;
  assign pend = en_s2_r & ~run_r & ~start_r;
  assign redge = bus.reconfig_if_clock & ~rck_q_r;
  assign bus.out_clk = out_r;
  assign bus.lock = lock_r;
  assign bus.reconfig_if_rbus = rbus_r;
  assign bus.reconfig_if_irq = irq_r;

  always_ff @(posedge pclk or negedge loop_rst_n) begin
    if (!loop_rst_n) begin
      ref_q_r <= 1'b0;
      rdiv_cnt_r <= '0;
      loss_cnt_r <= '0;
      ref_present <= 1'b0;
    end else begin
      ref_q_r <= ref_mux;
      if (ref_edge) begin
        rdiv_cnt_r <= ref_tick ? '0 : rdiv_cnt_r + 6'h01;
        loss_cnt_r <= '0;
        ref_present <= 1'b1;
      end else if (loss_cnt_r == 8'(REF_LOSS_CYC - 1)) begin
        ref_present <= 1'b0;
      end else begin
        loss_cnt_r <= loss_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge loop_rst_n) begin
    if (!loop_rst_n) begin
      fb_src_q_r <= 1'b0;
      fb_cnt_r <= '0;
      fb_mod_r <= '0;
      acc_r <= '0;
      fb_tick <= 1'b0;
    end else begin
      fb_src_q_r <= bus.feedback_clock_in;
      fb_tick <= 1'b0;
      if (fb_step) begin
        if (fb_cnt_r + 13'h0001 >= fb_mod_r) begin
          fb_cnt_r <= '0;
          fb_tick <= 1'b1;
          if (bus.fractional_part_mode) begin
            acc_r <= acc_nxt[FRACTIONAL_PART_W-1:0];
            fb_mod_r <= {1'b0, bus.feedback_divider} + {12'h000, acc_nxt[FRACTIONAL_PART_W]};
          end else begin
            acc_r <= '0;
            fb_mod_r <= {1'b0, bus.feedback_divider};
          end
        end else begin
          fb_cnt_r <= fb_cnt_r + 13'h0001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge loop_rst_n) begin
    if (!loop_rst_n) begin
      lk_cnt_r <= '0;
      lock_r <= 1'b0;
    end else if (!acq) begin
      lk_cnt_r <= '0;
      lock_r <= 1'b0;
    end else if (ref_tick) begin
      if (lk_cnt_r != lk_tgt) begin
        lk_cnt_r <= lk_cnt_r + 16'h0001;
      end
      lock_r <= lk_cnt_r == lk_tgt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      str_q_r <= 1'b0;
      rel_q_r <= 1'b1;
      phase_state <= PHASE_INIT;
    end else begin
      str_q_r <= bus.phase_step_strobe;
      rel_q_r <= bus.phase_reload_n;
      for (int i = 0; i < NOUT; i++) begin
        if (reload) begin
          phase_state[i*PH_W +: PH_W] <= PHASE_INIT[i*PH_W +: PH_W];
        end else if (step && bus.phase_pick[i]) begin
          phase_state[i*PH_W +: PH_W] <= bus.phase_dir ? phase_state[i*PH_W +: PH_W] + 3'h1
                                                     : phase_state[i*PH_W +: PH_W] - 3'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge loop_rst_n) begin
    if (!loop_rst_n) begin
      en_s1_r <= '0;
      en_s2_r <= '0;
      win_act_r <= 1'b0;
      win_cnt_r <= '0;
      start_r <= '0;
    end else begin
      en_s1_r <= bus.out_en;
      en_s2_r <= en_s1_r;
      start_r <= '0;
      if (!ref_present) begin
        win_act_r <= 1'b0;
      end else if (win_act_r) begin
        win_cnt_r <= win_cnt_r + 5'h01;
        if (win_cnt_r == 5'(ALIGN_OSC_CYC - 1)) begin
          win_act_r <= 1'b0;
          start_r <= pend;
        end
      end else if (|pend) begin
        win_act_r <= 1'b1;
        win_cnt_r <= '0;
      end
    end
  end

  for (genvar g = 0; g < NOUT; g++) begin : g_out
    logic [7:0] cnt_r;
    logic [1:0] inc;
    logic [8:0] cnt_n;
    logic hit;
    logic stop_one_r;
    logic [7:0] half;
    assign half = OUT_HALF[g*8 +: 8];
    assign inc = (step && bus.phase_pick[g]) ? (bus.phase_dir ? 2'h2 : 2'h0) : 2'h1;
    assign cnt_n = {1'b0, cnt_r} + {7'h00, inc};
    assign hit = cnt_n >= {1'b0, half};
    always_ff @(posedge pclk or negedge loop_rst_n) begin
      if (!loop_rst_n) begin
        run_r[g] <= 1'b0;
        out_r[g] <= 1'b0;
        cnt_r <= '0;
        stop_one_r <= 1'b0;
      end else if (!ref_present) begin
        run_r[g] <= 1'b0;
        out_r[g] <= 1'b0;
        stop_one_r <= 1'b0;
      end else if (start_r[g]) begin
        run_r[g] <= 1'b1;
        out_r[g] <= 1'b0;
        cnt_r <= {5'h00, phase_state[g*PH_W +: PH_W]};
        stop_one_r <= 1'b0;
      end else if (run_r[g]) begin
        if (hit) begin
          cnt_r <= 8'(cnt_n - {1'b0, half});
          out_r[g] <= ~out_r[g];
        end else begin
          cnt_r <= cnt_n[7:0];
        end
        if (en_s2_r[g]) begin
          stop_one_r <= 1'b0;
        end else if (hit && out_r[g]) begin
          stop_one_r <= 1'b1;
          if (stop_one_r) begin
            run_r[g] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge rc_rst_n) begin
    if (!rc_rst_n) begin
      rck_q_r <= 1'b0;
      raddr_r <= '0;
      rbus_r <= '0;
      for (int i = 0; i < RMEM_N; i++) begin
        rmem_r[i] <= '0;
      end
    end else begin
      rck_q_r <= bus.reconfig_if_clock;
      if (redge && bus.reconfig_if_ctrl[RC_VALID]) begin
        if (bus.reconfig_if_ctrl[RC_ADDR]) begin
          raddr_r <= bus.reconfig_if_wbus[7:0];
        end else if (bus.reconfig_if_ctrl[RC_WRITE]) begin
          if (raddr_r < 8'(RMEM_N)) begin
            rmem_r[raddr_r[1:0]] <= bus.reconfig_if_wbus;
          end
        end else if (raddr_r == RA_STATUS) begin
          rbus_r <= {29'h0, irq_r, ref_present, cfg_ok, lock_r};
        end else if (raddr_r < 8'(RMEM_N)) begin
          rbus_r <= rmem_r[raddr_r[1:0]];
        end else begin
          rbus_r <= '0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge rc_rst_n) begin
    if (!rc_rst_n) begin
      lock_seen_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      lock_seen_r <= lock_r;
      if (lock_seen_r != lock_r) begin
        irq_r <= 1'b1;
      end else if (redge && bus.reconfig_if_ctrl[RC_VALID] && bus.reconfig_if_ctrl[RC_ACK]) begin
        irq_r <= 1'b0;
      end
    end
  end
endmodule : pllc_dev

// ### rtl/pllc_host.sv
// User fabric end: APB registers that drive the loop control shell.
`timescale 1ns/1ps
module pllc_host #(
  parameter longint REF_HZ = 64'd50000000,
  parameter int RC_HALF = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  pllc_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fabric_por_n,
  input wire logic io_bank_supply_ok,
  output logic [pllc_pkg::NOUT-1:0] user_clk
);
  import pllc_pkg::*;

  logic [31:0] ctrl_r;
  logic [31:0] div_r;
  logic [FRACTIONAL_PART_W-1:0] fractional_part_r;
  logic [CTL_W-1:0] rctl_r;
  logic [BUS_W-1:0] rwd_r;
  logic step_r;
  logic load_n_r;
  logic lock_q_r;
  logic [7:0] rck_cnt_r;
  logic rck_r;
  logic wr;
  logic mapped;
  logic cfg_err;
  logic pfd_ok;
  logic supply_ready;
  logic [63:0] rd64;

  assign wr = psel & penable & pwrite;
  assign mapped = paddr[1:0] == 2'h0 && paddr <= A_RRD;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign rd64 = {58'h0, div_r[RDIV_W-1:0]};
  assign pfd_ok = ctrl_r[C_FRACTIONAL_PART] ? (REF_HZ >= rd64 * PFD_FR_MIN_HZ && REF_HZ <= rd64 * PFD_FR_MAX_HZ)
                                 : (REF_HZ >= rd64 * PFD_INT_MIN_HZ && REF_HZ <= rd64 * PFD_INT_MAX_HZ);
  assign cfg_err = !pfd_ok || !pllc_rdiv_ok(div_r[RDIV_W-1:0])
                   || !pllc_fdiv_ok(div_r[D_FDIV +: FDIV_W], ctrl_r[C_FRACTIONAL_PART]);
  assign supply_ready = ctrl_r[C_OSC] ? fabric_por_n : (fabric_por_n & io_bank_supply_ok);
  assign bus.loop_powerdown_n = supply_ready & ctrl_r[C_RUN] & ~cfg_err;
  assign bus.ref_sel = ctrl_r[C_SEL];
  assign bus.ext_fb = ctrl_r[C_EXTFB];
  assign bus.fractional_part_mode = ctrl_r[C_FRACTIONAL_PART];
  assign bus.out_en = ctrl_r[C_EN +: NOUT];
  assign bus.phase_pick = ctrl_r[C_PICK +: NOUT];
  assign bus.phase_dir = ctrl_r[C_DIR];
  assign bus.lock_delay_log2 = ctrl_r[C_LKL +: LKL_W];
  assign bus.reconfig_if_reset_n = ctrl_r[C_RREL];
  assign bus.reference_divider = div_r[RDIV_W-1:0];
  assign bus.feedback_divider = div_r[D_FDIV +: FDIV_W];
  assign bus.fractional_part = fractional_part_r;
  assign bus.phase_step_strobe = step_r;
  assign bus.phase_reload_n = load_n_r;
  assign bus.feedback_clock_in = ctrl_r[C_EXTFB] & bus.out_clk[0];
  assign bus.reconfig_if_clock = rck_r;
  assign bus.reconfig_if_ctrl = rctl_r;
  assign bus.reconfig_if_wbus = rwd_r;
  assign user_clk = bus.out_clk & {NOUT{bus.lock}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      lock_q_r <= 1'b0;
    end else begin
      lock_q_r <= bus.lock;
      if (wr && paddr == A_CTRL) begin
        ctrl_r <= pwdata;
      end
      if (ctrl_r[C_AUTO] && lock_q_r && !bus.lock && !ctrl_r[C_SEL]) begin
        ctrl_r[C_SEL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= DIV_RST;
      fractional_part_r <= '0;
      rctl_r <= '0;
      rwd_r <= '0;
    end else if (wr) begin
      case (paddr)
        A_DIV: div_r <= pwdata;
        A_FRACTIONAL_PART: fractional_part_r <= pwdata[FRACTIONAL_PART_W-1:0];
        A_RCTL: begin
          rctl_r <= pwdata[CTL_W-1:0];
          rwd_r[32] <= pwdata[W_BIT32];
        end
        A_RWD: rwd_r[31:0] <= pwdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_r <= 1'b0;
      load_n_r <= 1'b1;
    end else begin
      step_r <= wr && paddr == A_PHCMD && pwdata[P_STEP];
      load_n_r <= !(wr && paddr == A_PHCMD && pwdata[P_LOAD]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rck_cnt_r <= '0;
      rck_r <= 1'b0;
    end else if (rck_cnt_r == 8'(RC_HALF - 1)) begin
      rck_cnt_r <= '0;
      rck_r <= ~rck_r;
    end else begin
      rck_cnt_r <= rck_cnt_r + 8'h01;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      A_CTRL: prdata = ctrl_r;
      A_DIV: prdata = div_r;
      A_FRACTIONAL_PART: prdata = {8'h00, fractional_part_r};
      A_STAT: prdata = {26'h0, bus.reconfig_if_rbus[32], ctrl_r[C_SEL], bus.reconfig_if_irq,
                        bus.loop_powerdown_n, cfg_err, bus.lock};
      A_RCTL: prdata = {15'h0, rwd_r[32], 5'h00, rctl_r};
      A_RWD: prdata = rwd_r[31:0];
      A_RRD: prdata = bus.reconfig_if_rbus[31:0];
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule : pllc_host

// ### tb/pllc_chk.sv
// Concurrent checks on the signals joining the fabric end and the loop shell.
`timescale 1ns/1ps
module pllc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic loop_powerdown_n,
  input wire logic fractional_part_mode,
  input wire logic ext_fb,
  input wire logic [pllc_pkg::NOUT-1:0] out_en,
  input wire logic [pllc_pkg::NOUT-1:0] out_clk,
  input wire logic lock,
  input wire logic feedback_clock_in,
  input wire logic [pllc_pkg::RDIV_W-1:0] reference_divider,
  input wire logic [pllc_pkg::FDIV_W-1:0] feedback_divider,
  input wire logic reconfig_if_reset_n,
  input wire logic [pllc_pkg::CTL_W-1:0] reconfig_if_ctrl,
  input wire logic [pllc_pkg::BUS_W-1:0] reconfig_if_rbus,
  input wire logic reconfig_if_irq
);
  import pllc_pkg::*;
  logic [5:0] off_cnt_r;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Counts cycles with every enable low, so the slowest output has had time to stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_cnt_r <= 6'h00;
    end else if (out_en != 4'h0) begin
      off_cnt_r <= 6'h00;
    end else if (off_cnt_r != 6'h3F) begin
      off_cnt_r <= off_cnt_r + 6'h01;
    end
  end
  a_pd_out_low: assert property (!loop_powerdown_n |-> out_clk == 4'h0 && !lock)
    else $error("outputs or lock active while powered down");
  a_en_out_low: assert property (off_cnt_r >= 6'h28 |-> out_clk == 4'h0)
    else $error("output still running long after its enable fell");
  a_lock_delay: assert property ($rose(lock) |-> $past(loop_powerdown_n, 1) && $past(loop_powerdown_n, 4))
    else $error("lock rose without a settling delay");
  a_cfg_lock: assert property (lock |-> reference_divider != 6'h00 && (fractional_part_mode ?
    (feedback_divider >= 12'h014 && feedback_divider <= 12'h1F4) :
    (feedback_divider >= 12'h008 && feedback_divider != 12'h00B)))
    else $error("lock held with an invalid divider");
  a_rc_reset: assert property (!reconfig_if_reset_n |-> reconfig_if_rbus == 33'h0_0000_0000 && !reconfig_if_irq)
    else $error("reconfiguration outputs active in reset");
  a_irq_hold: assert property ($fell(reconfig_if_irq) |-> !reconfig_if_reset_n || $past(reconfig_if_ctrl[RC_ACK]))
    else $error("interrupt dropped without service");
  a_irq_set: assert property ($changed(lock) && reconfig_if_reset_n |-> ##[0:2] reconfig_if_irq)
    else $error("lock change raised no interrupt");
  a_fb_route: assert property (feedback_clock_in == (ext_fb & out_clk[0]))
    else $error("feedback input not fed from output zero");
endmodule : pllc_chk

// ### tb/pll_control_logic_tb.sv
// Self-checking bench for the fabric end and loop shell joined through their interface.
`timescale 1ns/1ps
module pll_control_logic_tb;
  import pllc_pkg::*;
  typedef struct packed {
    logic [31:0] val;
    logic [31:0] mask;
    logic err;
  } pllc_note_t;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fabric_por_n;
  logic io_bank_supply_ok;
  logic [NOUT-1:0] user_clk;
  logic ref_clk0;
  logic ref_clk1;
  logic ref_on0;
  logic ref_on1;
  logic fb_tick;
  logic ref_present;
  logic [NOUT*PH_W-1:0] phase_state;
  logic [31:0] ctrl;
  logic [31:0] rdat;
  logic [2:0] ph [NOUT];
  logic [3:0] pick;
  logic dir;
  logic last;
  int n;
  int fails;
  int checks_done;
  int cyc;
  pllc_note_t note;
  pllc_note_t notes[$];
  // Each entry: error, fractional mode, reference divide, feedback divide.
  logic [19:0] cfg_tab [13] = '{20'h01008, 20'h0100A, 20'h8100B, 20'h01FFF, 20'h81007, 20'h3200C, 20'hB300C,
    20'h8000C, 20'h45014, 20'hC6014, 20'h411F4, 20'hC11F5, 20'hC1013};
  pllc_if bus();
  pllc_host i_pllc_host (.pclk(pclk), .presetn(presetn), .bus(bus), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fabric_por_n(fabric_por_n), .io_bank_supply_ok(io_bank_supply_ok), .user_clk(user_clk));
  pllc_dev i_pllc_dev (.pclk(pclk), .presetn(presetn), .bus(bus), .ref_clk0(ref_clk0), .ref_clk1(ref_clk1),
    .ref_present(ref_present), .fb_tick(fb_tick), .phase_state(phase_state));
  pllc_chk i_pllc_chk (.pclk(pclk), .presetn(presetn), .loop_powerdown_n(bus.loop_powerdown_n),
    .fractional_part_mode(bus.fractional_part_mode), .ext_fb(bus.ext_fb), .out_en(bus.out_en), .out_clk(bus.out_clk),
    .lock(bus.lock), .feedback_clock_in(bus.feedback_clock_in), .reference_divider(bus.reference_divider),
    .feedback_divider(bus.feedback_divider), .reconfig_if_reset_n(bus.reconfig_if_reset_n),
    .reconfig_if_ctrl(bus.reconfig_if_ctrl), .reconfig_if_rbus(bus.reconfig_if_rbus),
    .reconfig_if_irq(bus.reconfig_if_irq));

  task automatic report_and_stop();
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic e);
    notes.push_back('{d, m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask : rd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Reference clocks run at one eighth of pclk; the cycle ceiling cuts a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) begin
      ref_clk0 <= ref_on0 & ~ref_clk0;
      ref_clk1 <= ref_on1 & ~ref_clk1;
    end
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  always @(posedge pclk) begin
    if ((psel && penable && pready) === 1'b1) begin
      note = notes.pop_front();
      checks_done++;
      if ((prdata & note.mask) !== (note.val & note.mask) || pslverr !== note.err) begin
        fails++;
        $display("unexpected at %0t: addr %h read %h", $time, paddr, prdata);
      end
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, fabric_por_n, io_bank_supply_ok} = 6'h00;
    {ref_on0, ref_on1} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    {cyc, fails, checks_done} = {32'h0, 32'h0, 32'h0};
    ph = '{3'h0, 3'h0, 3'h0, 3'h0};
    void'($urandom(73));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    fabric_por_n <= 1'b1;
    rd(A_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    rd(A_DIV, DIV_RST, 32'hFFFF_FFFF);
    rd(A_PHCMD, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(A_STAT, 32'h0000_0000, 32'h0000_001F);
    apb(1'b0, 8'h20, 32'h0000_0000, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h06, 32'h0000_0000, 32'h0000_0000, 1'b1);
    ctrl = 32'h0020_0000;
    foreach (cfg_tab[k]) begin
      wr(A_CTRL, ctrl | {26'h0, cfg_tab[k][18], 5'h00});
      wr(A_DIV, {4'h0, cfg_tab[k][11:0], 10'h000, cfg_tab[k][17:12]});
      rd(A_STAT, {30'h0, cfg_tab[k][19], 1'b0}, 32'h0000_0002);
    end
    for (int k = 0; k < 8; k++) begin
      pick = 4'($urandom_range(15));
      dir = 1'($urandom_range(1));
      wr(A_CTRL, ctrl | {15'h0000, dir, pick, 12'h000});
      wr(A_PHCMD, 32'h0000_0001);
      foreach (ph[i]) begin
        if (pick[i]) begin
          ph[i] = dir ? ph[i] + 3'h1 : ph[i] - 3'h1;
        end
      end
      wait_cyc(2);
      check({20'h0, phase_state}, {20'h0, ph[3], ph[2], ph[1], ph[0]});
    end
    wr(A_PHCMD, 32'h0000_0002);
    wait_cyc(2);
    check({20'h0, phase_state}, 32'h0000_0000);
    wr(A_DIV, DIV_RST);
    ctrl = 32'h0120_0001;
    ref_on0 <= 1'b1;
    wr(A_CTRL, ctrl);
    rd(A_STAT, 32'h0000_0000, 32'h0000_0005);
    io_bank_supply_ok <= 1'b1;
    rd(A_STAT, 32'h0000_0000, 32'h0000_0001);
    wait_cyc(200);
    rd(A_STAT, 32'h0000_000D, 32'h0000_001D);
    wr(A_CTRL, ctrl | 32'h0000_0100);
    wr(A_CTRL, ctrl | 32'h0000_0300);
    wait_cyc(30);
    n = 0;
    last = user_clk[0];
    repeat (40) begin
      @(negedge pclk);
      if (user_clk[0] === 1'b1 && last === 1'b0) begin
        n++;
      end
      last = user_clk[0];
      if (bus.out_clk[1] !== bus.out_clk[0]) begin
        n = n + 100;
      end
    end
    check(32'(n), 32'h0000_000A);
    wr(A_CTRL, ctrl);
    wait_cyc(40);
    check({28'h0, bus.out_clk}, 32'h0000_0000);
    rdat = $urandom;
    wr(A_RWD, 32'h0000_0002);
    wr(A_RCTL, 32'h0000_0005);
    wait_cyc(8);
    wr(A_RCTL, 32'h0001_0003);
    wr(A_RWD, rdat);
    wait_cyc(8);
    wr(A_RCTL, 32'h0000_0001);
    wait_cyc(8);
    rd(A_RRD, rdat, 32'hFFFF_FFFF);
    rd(A_STAT, 32'h0000_0028, 32'h0000_0028);
    wr(A_RCTL, 32'h0000_0009);
    wait_cyc(8);
    wr(A_RCTL, 32'h0000_0000);
    rd(A_STAT, 32'h0000_0001, 32'h0000_0009);
    wr(A_CTRL, ctrl & 32'hFFFF_FFFE);
    rd(A_STAT, 32'h0000_0008, 32'h0000_000D);
    check({28'h0, user_clk}, 32'h0000_0000);
    wr(A_CTRL, 32'h0020_0000);
    rd(A_RRD, 32'h0000_0000, 32'hFFFF_FFFF);
    ref_on0 <= 1'b0;
    ref_on1 <= 1'b1;
    wr(A_CTRL, 32'h0020_0F03);
    wait_cyc(200);
    rd(A_STAT, 32'h0000_0015, 32'h0000_0015);
    ref_on1 <= 1'b0;
    wait_cyc(150);
    rd(A_STAT, 32'h0000_0014, 32'h0000_0015);
    check({28'h0, bus.out_clk}, 32'h0000_0000);
    check({31'h0, ref_present}, 32'h0000_0000);
    wr(A_DIV, 32'h0014_0001);
    wr(A_FRACTIONAL_PART, 32'h0080_0000);
    ref_on0 <= 1'b1;
    io_bank_supply_ok <= 1'b0;
    wr(A_CTRL, 32'h0020_002D);
    wait_cyc(200);
    rd(A_STAT, 32'h0000_0005, 32'h0000_0017);
    n = 0;
    repeat (820) begin
      @(negedge pclk);
      if (fb_tick === 1'b1) begin
        n++;
      end
    end
    check(32'(n), 32'h0000_0028);
    ref_on0 <= 1'b0;
    ref_on1 <= 1'b1;
    wait_cyc(200);
    rd(A_STAT, 32'h0000_0015, 32'h0000_0015);
    check({31'h0, ref_present}, 32'h0000_0001);
    report_and_stop();
  end

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask : wait_cyc
endmodule : pll_control_logic_tb
